// file: design/can_fault_defs.vh
`ifndef CAN_FAULT_DEFS_VH
`define CAN_FAULT_DEFS_VH

// Register byte offsets
`define OFS_MODE        8'h00
`define OFS_DIAG        8'h04
`define OFS_INT_STATUS  8'h08
`define OFS_INT_MASK    8'h0C
`define OFS_CMD         8'h10

// Transceiver mode encodings
`define MODE_OFF        2'h0
`define MODE_WAKE       2'h1
`define MODE_NORMAL     2'h2
`define MODE_RXONLY     2'h3

// Event / diagnostic bit positions
`define EV_DOM_CLAMP    0
`define EV_TX_RX_SHORT  1
`define EV_OVERTEMP     2
`define EV_RX_RECESSIVE 3
`define EV_BUS_FAIL     4
`define EV_TX_TIMEOUT   5
`define EV_UNDERVOLT    6
`define EV_COUNT        7

// Diagnostic code for transmit input shorted to ground
`define DIAG_TXD_GND    3'h1

// Command register bits
`define CMD_REENABLE    0

// Reset values
`define MODE_RESET      2'h0
`define MASK_RESET      7'h00

// Timing, microseconds, at a 10 MHz clock; RX recessive limit counts bus edges
`define CLK_MHZ         10
`define DOM_CLAMP_US    1000
`define TX_TIMEOUT_US   1000
`define RX_REC_BITS     16

`endif

// file: design/can_fault_supervisor.v
// Operation
// - Long bus dominant: flag, go receive-only
// - Clamp reported, interrupt unless masked
// - TX-RX short inhibits transmitter until command
// - TX-RX short raises interrupt unless masked
// - Overtemperature disables; cooled restores, mode kept
// - After cooling, wait TX dominant-to-recessive edge
// - RX recessive during traffic disables transmitter
// - RX recessive inhibit held until command
// - Undervoltage from regulator monitor only
// - Any bus-line short sets bus flag, interrupt
// - Bus-line short leaves mode unchanged
// - Split stabiliser on in normal, receive-only
// - TX timeout reported as TX shorted ground
// - TX timeout blocks driver until mode written to normal
`include "can_fault_defs.vh"
`default_nettype none

module can_fault_supervisor #(
	parameter DOM_CLAMP_CYC = `DOM_CLAMP_US * `CLK_MHZ,
	parameter TX_TO_CYC     = `TX_TIMEOUT_US * `CLK_MHZ,
	parameter RX_REC_EDGES  = `RX_REC_BITS
) (
	// Clock and reset
	input  wire        clk_in,
	input  wire        resetn_in,
	// AXI4-Lite write address and data
	input  wire [7:0]  s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	output reg  [1:0]  s_axi_bresp_out,
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	// AXI4-Lite read
	input  wire [7:0]  s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// Controller pins: txd low is dominant
	input  wire        txd_in,
	output reg         rxd_out,
	input  wire        rxd_sense_in, // Receive pad level, read back
	// Bus side: receiver result (high = dominant) and fault sensors
	input  wire        bus_dominant_in,
	input  wire        overtemp_in,
	input  wire [5:0]  bus_short_in,
	input  wire        supply_undervolt_in,
	// Transmitter, receiver and split controls
	output reg         driver_en_out,
	output reg         receiver_en_out,
	output reg         split_en_out,
	output reg         irq_out
);

	// Synchronised pins
	wire       txd_s;
	wire       rxs_s;
	wire       bus_dom_s;
	wire       ot_s;
	wire       uv_s;
	wire [5:0] short_s;

	pin_sync #(.W(11)) u_sync (
		.clk_in       (clk_in),
		.resetn_in    (resetn_in),
		.reset_val_in (11'h003),
		.async_in     ({supply_undervolt_in, bus_short_in, overtemp_in,
		                bus_dominant_in, rxd_sense_in, txd_in}),
		.sync_out     ({uv_s, short_s, ot_s, bus_dom_s, rxs_s, txd_s})
	);

	// Control and status state
	reg [1:0]  mode_reg;
	reg [`EV_COUNT-1:0] status_reg;
	reg [`EV_COUNT-1:0] mask_reg;
	reg        clamp_inh_reg;
	reg        short_inh_reg;
	reg        rxrec_inh_reg;
	reg        txto_inh_reg;
	reg        ot_wait_reg;
	reg        txd_prev_reg;
	reg [31:0] dom_cnt_reg;
	reg [31:0] tx_cnt_reg;
	reg [7:0]  rec_cnt_reg;
	reg        bus_prev_reg;
	reg        ws_reg;
	reg [7:0]  aw_reg;
	reg [31:0] wd_reg;
	reg        aw_full_reg;
	reg        w_full_reg;

	// Active modes (normal and receive-only) share this decode
	function active_mode;
		input [1:0] m;
		begin
			active_mode = (m == `MODE_NORMAL) || (m == `MODE_RXONLY);
		end
	endfunction

	wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
	wire wr_mode = wr_go && aw_reg == `OFS_MODE && ws_reg;
	wire wr_cmd_go = wr_go && aw_reg == `OFS_CMD && wd_reg[`CMD_REENABLE];
	wire in_normal = (mode_reg == `MODE_NORMAL);
	wire txd_dom = !txd_s;
	wire rx_active = active_mode(mode_reg) && !ot_s;
	// Looped-back transmitter: dominant sent but not seen means short
	wire tx_rx_short = in_normal && driver_en_out && txd_dom && !bus_dom_s;
	wire bus_edge = bus_dom_s && !bus_prev_reg;

	// Event pulses and levels (overtemp, bus fail, undervolt)
	reg  [`EV_COUNT-1:0] ev;
	always @* begin
		ev = {`EV_COUNT{1'b0}};
		ev[`EV_DOM_CLAMP]    = rx_active && bus_dom_s &&
		                       dom_cnt_reg == DOM_CLAMP_CYC;
		ev[`EV_TX_RX_SHORT]  = tx_rx_short && !short_inh_reg;
		ev[`EV_OVERTEMP]     = ot_s;
		ev[`EV_RX_RECESSIVE] = !rxrec_inh_reg &&
		                       rec_cnt_reg == RX_REC_EDGES;
		ev[`EV_BUS_FAIL]     = |short_s;
		ev[`EV_TX_TIMEOUT]   = txd_dom && tx_cnt_reg == TX_TO_CYC;
		ev[`EV_UNDERVOLT]    = uv_s;
	end

	// Fault counters: dominant clamp, TX timeout, RX recessive traffic
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			dom_cnt_reg  <= 32'h0000_0000;
			tx_cnt_reg   <= 32'h0000_0000;
			rec_cnt_reg  <= 8'h00;
			bus_prev_reg <= 1'b0;
		end else begin
			bus_prev_reg <= bus_dom_s;
			if (bus_dom_s && dom_cnt_reg <= DOM_CLAMP_CYC)
				dom_cnt_reg <= dom_cnt_reg + 32'h0000_0001;
			else if (!bus_dom_s)
				dom_cnt_reg <= 32'h0000_0000;
			if (txd_dom && tx_cnt_reg <= TX_TO_CYC)
				tx_cnt_reg <= tx_cnt_reg + 32'h0000_0001;
			else if (!txd_dom)
				tx_cnt_reg <= 32'h0000_0000;
			// Bus edges counted while the pad still reads recessive;
			// the pad lags the bus, so a healthy echo clears it later
			if (!rx_active || !rxs_s || wr_cmd_go)
				rec_cnt_reg <= 8'h00;
			else if (bus_edge && rec_cnt_reg != 8'hFF)
				rec_cnt_reg <= rec_cnt_reg + 8'h01;
		end
	end

	// Mode and inhibit flags
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			mode_reg      <= `MODE_RESET;
			clamp_inh_reg <= 1'b0;
			short_inh_reg <= 1'b0;
			rxrec_inh_reg <= 1'b0;
			txto_inh_reg  <= 1'b0;
			ot_wait_reg   <= 1'b0;
			txd_prev_reg  <= 1'b1;
		end else begin
			txd_prev_reg <= txd_s;
			if (wr_mode) begin
				mode_reg <= wd_reg[1:0];
				if (wd_reg[1:0] == `MODE_NORMAL) begin
					clamp_inh_reg <= 1'b0;
					txto_inh_reg  <= 1'b0;
				end
			end
			if (ev[`EV_DOM_CLAMP]) begin
				mode_reg      <= `MODE_RXONLY;
				clamp_inh_reg <= 1'b1;
			end
			// Re-enable command clears latched short inhibits
			if (wr_cmd_go) begin
				short_inh_reg <= 1'b0;
				rxrec_inh_reg <= 1'b0;
			end
			if (ev[`EV_TX_RX_SHORT])
				short_inh_reg <= 1'b1;
			if (ev[`EV_RX_RECESSIVE])
				rxrec_inh_reg <= 1'b1;
			if (ev[`EV_TX_TIMEOUT])
				txto_inh_reg <= 1'b1;
			// Mode is kept; transmit released on a TX rising edge
			if (ot_s)
				ot_wait_reg <= 1'b1;
			else if (ot_wait_reg && txd_s && !txd_prev_reg)
				ot_wait_reg <= 1'b0;
		end
	end

	// Sticky status, set beats write-one-to-clear
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			status_reg <= {`EV_COUNT{1'b0}};
		end else begin
			if (wr_go && aw_reg == `OFS_INT_STATUS)
				status_reg <= (status_reg & ~wd_reg[`EV_COUNT-1:0]) | ev;
			else
				status_reg <= status_reg | ev;
		end
	end

	// Pin outputs; bus short never changes mode
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			driver_en_out   <= 1'b0;
			receiver_en_out <= 1'b0;
			split_en_out    <= 1'b0;
			rxd_out         <= 1'b1;
			irq_out         <= 1'b0;
		end else begin
			driver_en_out   <= in_normal && !ot_s && !ot_wait_reg &&
			                   !clamp_inh_reg && !short_inh_reg &&
			                   !rxrec_inh_reg && !txto_inh_reg;
			receiver_en_out <= rx_active;
			split_en_out    <= active_mode(mode_reg);
			rxd_out         <= !(rx_active && bus_dom_s);
			irq_out         <= |(status_reg & ~mask_reg);
		end
	end

	// AXI4-Lite write channel: capture address and data in any order
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= 2'b00;
			aw_full_reg       <= 1'b0;
			w_full_reg        <= 1'b0;
			aw_reg            <= 8'h00;
			wd_reg            <= 32'h0000_0000;
			ws_reg            <= 1'b0;
			mask_reg          <= `MASK_RESET;
		end else begin
			s_axi_awready_out <= !aw_full_reg && !s_axi_awready_out;
			s_axi_wready_out  <= !w_full_reg && !s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_full_reg       <= 1'b1;
				aw_reg            <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_full_reg       <= 1'b1;
				wd_reg           <= s_axi_wdata_in;
				ws_reg           <= s_axi_wstrb_in[0];
				s_axi_wready_out <= 1'b0;
			end
			if (wr_go) begin
				aw_full_reg      <= 1'b0;
				w_full_reg       <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				case (aw_reg)
				`OFS_MODE, `OFS_INT_STATUS, `OFS_CMD:
					s_axi_bresp_out <= 2'b00;
				`OFS_INT_MASK: begin
					s_axi_bresp_out <= 2'b00;
					mask_reg <= wd_reg[`EV_COUNT-1:0];
				end
				`OFS_DIAG:
					s_axi_bresp_out <= 2'b00;
				default:
					s_axi_bresp_out <= 2'b10;
				endcase
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// Diagnostic word: live inhibits and TX short-to-ground code
	wire [31:0] diag_word = {18'h0_0000, 3'b000,
		(txto_inh_reg ? `DIAG_TXD_GND : 3'h0),
		ot_wait_reg, ot_s, rxrec_inh_reg, short_inh_reg,
		clamp_inh_reg, txto_inh_reg, |short_s, uv_s};

	// AXI4-Lite read channel, one cycle from address to data
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= 2'b00;
		end else begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rresp_out   <= 2'b00;
				case (s_axi_araddr_in)
				`OFS_MODE:
					s_axi_rdata_out <= {30'h0000_0000, mode_reg};
				`OFS_DIAG:
					s_axi_rdata_out <= diag_word;
				`OFS_INT_STATUS:
					s_axi_rdata_out <= {25'h000_0000, status_reg};
				`OFS_INT_MASK:
					s_axi_rdata_out <= {25'h000_0000, mask_reg};
				`OFS_CMD:
					s_axi_rdata_out <= 32'h0000_0000;
				default: begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// file: design/pin_sync.v
`default_nettype none

// Three-stage input synchroniser; change accepted when stages 2 and 3 agree
module pin_sync #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         clk_in,
	input  wire         resetn_in,
	input  wire [W-1:0] reset_val_in,
	// Data
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;

	// All stages load the idle level, so no false edge follows reset
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			s1_reg <= reset_val_in;
			s2_reg <= reset_val_in;
			s3_reg <= reset_val_in;
			sync_out <= reset_val_in;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				sync_out <= s3_reg;
		end
	end

endmodule

`default_nettype wire

// file: tb/can_bus_model.sv
`default_nettype none
module can_bus_model (
	// Clock and scenario knobs
	input  wire logic clk_in,
	input  wire logic clamp_in,
	input  wire logic cut_in,
	input  wire logic slow_in,
	input  wire logic stuck_in,
	// Transceiver side
	input  wire logic driver_en_in,
	input  wire logic txd_in,
	input  wire logic rxd_in,
	output logic      bus_dominant_out,
	output logic      rxd_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic now_w;
	logic lag_reg;
	// Bus echoes our driver unless the lines are cut off
	assign now_w = clamp_in || (driver_en_in && !txd_in && !cut_in);
	// Slow bus settles one cycle late
	always @(posedge clk_in) lag_reg <= now_w;
	assign bus_dominant_out = slow_in ? lag_reg : now_w;
	// Pad shorted high reads recessive whatever the bus does
	assign rxd_pin_out = rxd_in || stuck_in;
endmodule
`default_nettype wire

// file: tb/can_fault_monitor.sv
`default_nettype none
module can_fault_monitor #(
	parameter DOM_CLAMP_CYC = 10000,
	parameter TX_TO_CYC     = 10000
) (
	// Clock, reset and inputs
	input wire logic       clk_in,
	input wire logic       resetn_in,
	input wire logic       s_axi_wvalid_in,
	input wire logic       txd_in,
	input wire logic       bus_dominant_in,
	input wire logic       overtemp_in,
	input wire logic [5:0] bus_short_in,
	// Outputs
	input wire logic       s_axi_bvalid_out,
	input wire logic       rxd_out,
	input wire logic       driver_en_out,
	input wire logic       receiver_en_out,
	input wire logic       split_en_out,
	input wire logic       irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int dcnt;
	int tcnt;
	int wgap;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// Run lengths; write gap saturates so it never wraps
	always @(posedge clk_in) begin
		dcnt <= (resetn_in && bus_dominant_in) ? dcnt + 1 : 0;
		tcnt <= (resetn_in && !txd_in) ? tcnt + 1 : 0;
		wgap <= (!resetn_in || s_axi_wvalid_in) ? 0 : wgap + (wgap < 99);
	end
	split_drv_a:
		assert property (driver_en_out |-> split_en_out)
		else $error("driver on while split off");
	clamp_off_a:
		assert property (dcnt == DOM_CLAMP_CYC + 8 |-> !driver_en_out)
		else $error("bus clamp left driver on");
	clamp_rx_a:
		assert property (dcnt == DOM_CLAMP_CYC + 8 |-> receiver_en_out)
		else $error("bus clamp dropped receiver");
	txto_off_a:
		assert property (tcnt == TX_TO_CYC + 8 |-> !driver_en_out)
		else $error("long txd dominant left driver on");
	ovt_off_a:
		assert property (overtemp_in [*8] |-> !driver_en_out && !receiver_en_out)
		else $error("overtemperature left transceiver on");
	rxd_follow_a:
		assert property ((bus_dominant_in && split_en_out && receiver_en_out)
			[*8] |-> !rxd_out)
		else $error("rxd not dominant on dominant bus");
	short_mode_a:
		assert property ($changed(split_en_out) && |bus_short_in |-> wgap < 8)
		else $error("bus short changed mode");
	bresp_after_a:
		assert property ($rose(s_axi_bvalid_out) |-> wgap < 4)
		else $error("write response without write");
	cover property (dcnt == DOM_CLAMP_CYC + 8);
	cover property (overtemp_in [*8]);
	cover property ($rose(irq_out));
endmodule
bind can_fault_supervisor can_fault_monitor #(
	.DOM_CLAMP_CYC(DOM_CLAMP_CYC),
	.TX_TO_CYC    (TX_TO_CYC)
) i_can_fault_monitor (
	.clk_in(clk_in), .resetn_in(resetn_in),
	.s_axi_wvalid_in(s_axi_wvalid_in), .txd_in(txd_in),
	.bus_dominant_in(bus_dominant_in), .overtemp_in(overtemp_in),
	.bus_short_in(bus_short_in), .s_axi_bvalid_out(s_axi_bvalid_out),
	.rxd_out(rxd_out), .driver_en_out(driver_en_out),
	.receiver_en_out(receiver_en_out), .split_en_out(split_en_out),
	.irq_out(irq_out)
);
`default_nettype wire

// file: tb/can_transceiver_fault_supervisor_tb_top.sv
`include "can_fault_defs.vh"
`default_nettype none
module can_transceiver_fault_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, resetn_in = 0, awv = 0, wv = 0, bry = 0, arv = 0;
	logic rry = 0, txd = 1, otemp = 0, uv = 0, clamp = 0, cut = 0, slow = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, m, rdata;
	logic [5:0] shorts = 0;
	logic [1:0] bresp, rresp;
	logic [1:0] bq[$];
	logic stuck = 0, rxp;
	logic awrdy, wrdy, bval, arrdy, rval, rxd, drv, rcv, split, irq, dom;
	logic [65:0] exp_q[$], n;
	int error_cnt = 0, checks_done = 0, cyc = 0, i;
	always #50 clk_in = ~clk_in;
	can_fault_supervisor #(.DOM_CLAMP_CYC(40), .TX_TO_CYC(20),
		.RX_REC_EDGES(3)) i_can_fault_supervisor (
		.clk_in(clk_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bval), .s_axi_bready_in(bry),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rval),
		.s_axi_rready_in(rry), .txd_in(txd), .rxd_out(rxd),
		.rxd_sense_in(rxp),
		.bus_dominant_in(dom), .overtemp_in(otemp), .bus_short_in(shorts),
		.supply_undervolt_in(uv), .driver_en_out(drv),
		.receiver_en_out(rcv), .split_en_out(split), .irq_out(irq));
	can_bus_model i_can_bus_model (.clk_in(clk_in), .clamp_in(clamp),
		.cut_in(cut), .slow_in(slow), .driver_en_in(drv), .txd_in(txd),
		.stuck_in(stuck), .rxd_in(rxd), .rxd_pin_out(rxp),
		.bus_dominant_out(dom));
	task automatic wt(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmp(input logic [33:0] g, input logic [33:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic pin(input logic g, input logic e);
		cmp({33'h0, g}, {33'h0, e});
	endtask
	// Bus master: payload held until each ready, then one idle edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		bq.push_back((a > `OFS_CMD || a[1:0] != 2'b00) ? 2'b10 : 2'b00);
		do begin
			@(posedge clk_in);
			if (awrdy) awv <= 0;
			if (wrdy) wv <= 0;
		end while (!bval);
		bry <= 0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] k, input logic [1:0] r);
		araddr <= a;
		arv <= 1;
		rry <= 1;
		exp_q.push_back({r, k, e});
		do begin
			@(posedge clk_in);
			if (arrdy) arv <= 0;
		end while (!rval);
		rry <= 0;
		@(posedge clk_in);
	endtask
	// Read answers are compared against notes in issue order
	always @(posedge clk_in) begin
		if (rval && rry) begin
			n = exp_q.pop_front();
			cmp({rresp, rdata & n[63:32]}, {n[65:64], n[31:0]});
		end
		if (bval && bry)
			cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
	end
	// Hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		m = $urandom(32'he8c4_1840);
		wt(8);
		resetn_in <= 1;
		wt(1);
		pin(rxd, 1);
		pin(split, 0);
		rd(`OFS_INT_MASK, 0, 32'h7f, 0);
		wr(8'h14, 32'hffff_ffff);
		rd(8'h14, 0, 0, 2'h2);
		rd(`OFS_MODE, 0, 3, 0);
		wr(`OFS_MODE, 2);
		wt(8);
		pin(split, 1);
		pin(drv, 1);
		// Every kind of line short, interrupt unmasked by random mask
		m = $urandom & 32'h6f;
		wr(`OFS_INT_MASK, m);
		rd(`OFS_INT_MASK, m, 32'h7f, 0);
		for (i = 0; i < 6; i++) begin
			shorts <= 6'h01 << i;
			wt(8);
			pin(irq, 1);
			pin(split, 1);
			rd(`OFS_INT_STATUS, 32'h10, 32'h10, 0);
			rd(`OFS_MODE, 2, 3, 0);
			shorts <= 0;
			// Live short keeps setting the flag through the synchroniser
			wt(8);
			wr(`OFS_INT_STATUS, 32'h10);
			wt(4);
			pin(irq, 0);
		end
		shorts <= 6'h3f;
		wr(`OFS_INT_MASK, m | 32'h10);
		wt(8);
		pin(irq, 0);
		shorts <= 0;
		wt(8);
		wr(`OFS_INT_STATUS, 32'h7f);
		wr(`OFS_INT_MASK, 0);
		// Overtemperature, then release on a txd rising edge
		otemp <= 1;
		wt(8);
		pin(rcv, 0);
		otemp <= 0;
		wt(8);
		pin(rcv, 1);
		pin(drv, 0);
		rd(`OFS_DIAG, 32'h80, 32'h80, 0);
		rd(`OFS_MODE, 2, 3, 0);
		txd <= 0;
		wt(6);
		txd <= 1;
		wt(8);
		pin(drv, 1);
		rd(`OFS_INT_STATUS, 4, 4, 0);
		wr(`OFS_INT_STATUS, 32'h7f);
		// Bus clamped dominant on a slow bus
		slow <= 1;
		clamp <= 1;
		wt(52);
		pin(rcv, 1);
		pin(irq, 1);
		rd(`OFS_MODE, 3, 3, 0);
		rd(`OFS_INT_STATUS, 1, 1, 0);
		rd(`OFS_DIAG, 8, 8, 0);
		clamp <= 0;
		slow <= 0;
		wt(20);
		pin(drv, 0);
		wr(`OFS_MODE, 2);
		wt(4);
		pin(drv, 1);
		wr(`OFS_INT_STATUS, 32'h7f);
		// Transmit dominant timeout
		txd <= 0;
		wt(32);
		rd(`OFS_DIAG, 32'h104, 32'h704, 0);
		rd(`OFS_INT_STATUS, 32'h20, 32'h20, 0);
		txd <= 1;
		wt(8);
		pin(drv, 0);
		wr(`OFS_MODE, 2);
		wt(4);
		pin(drv, 1);
		wr(`OFS_INT_STATUS, 32'h7f);
		// Transmit echo missing on the receive side
		cut <= 1;
		txd <= 0;
		wt(8);
		pin(drv, 0);
		pin(irq, 1);
		rd(`OFS_INT_STATUS, 2, 2, 0);
		rd(`OFS_DIAG, 32'h10, 32'h10, 0);
		txd <= 1;
		cut <= 0;
		wt(8);
		pin(drv, 0);
		wr(`OFS_CMD, 1);
		wt(4);
		pin(drv, 1);
		wr(`OFS_INT_STATUS, 32'h7f);
		// Receive pad stuck recessive while own frames go out
		stuck <= 1;
		repeat (3) begin
			txd <= 0;
			wt(3);
			txd <= 1;
			wt(3);
		end
		wt(4);
		pin(drv, 0);
		rd(`OFS_INT_STATUS, 8, 8, 0);
		rd(`OFS_DIAG, 32'h20, 32'h20, 0);
		stuck <= 0;
		wt(8);
		pin(drv, 0);
		wr(`OFS_CMD, 1);
		wt(4);
		pin(drv, 1);
		wr(`OFS_INT_STATUS, 32'h7f);
		// Regulator undervoltage, host then walks the modes
		uv <= 1;
		wt(8);
		rd(`OFS_DIAG, 1, 1, 0);
		rd(`OFS_MODE, 2, 3, 0);
		uv <= 0;
		for (i = 0; i < 4; i++) begin
			wr(`OFS_MODE, i);
			wt(4);
			pin(split, i >= 2);
		end
		pin(drv, 0);
		test_done();
	end
endmodule
`default_nettype wire
